// ===== src/mram_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mram_bus_if;
  import mram_port_pkg::*;
  logic [IDX_W-1:0] cell_index;
  logic write_n;
  logic [DIE_N-1:0] die_sel_n;
  logic out_gate;
  logic byte_mode_sel;
  logic burst_read_mode;
  logic count_arm;
  logic count_stop;
  logic wrap_guard;
  logic last_addr;
  logic [DIE_N-1:0] corr_err;
  logic [DQ_W-1:0] host_dq_out;
  logic [DQ_W-1:0] host_dq_oe;
  logic [DQ_W-1:0] dev_dq_out;
  logic [DQ_W-1:0] dev_dq_oe;
  wire [DQ_W-1:0] dq;
  // undriven lines settle low, as if pulled to ground
  assign dq = (dev_dq_out & dev_dq_oe) | (host_dq_out & host_dq_oe);
  modport device (
    input cell_index, write_n, die_sel_n, out_gate, byte_mode_sel, burst_read_mode,
    input count_arm, count_stop, wrap_guard, dq,
    output last_addr, corr_err, dev_dq_out, dev_dq_oe
  );
  modport host (
    output cell_index, write_n, die_sel_n, out_gate, byte_mode_sel, burst_read_mode,
    output count_arm, count_stop, wrap_guard, host_dq_out, host_dq_oe,
    input last_addr, corr_err, dq
  );
endinterface
`default_nettype wire

// ===== src/mram_device.sv
// Summary of operation
// - every rising edge samples index, strobe, selects, data
// - low select enables access to its die
// - high select leaves die deselected, drivers off
// - host selects one die, or all in burst
// - index picks byte; word mode top bit low
// - shared bus; byte mode uses low lines only; host byte-mode writes still drive all 16 lines
// - strobe low writes, outputs off; high reads
// - output gate low floats outputs; tie high; the host drives it from ctrl bit CTRL_GATE instead
// - byte strap picks index and width; static
// - burst mode reads from counter; exit resets it
// - burst needs all selects and strobe low
// - arm low, stop high, guard low reset counter
// - counter advances on arm, not stop, guard
// - last-address flag once counter hits end
// - per-die flag after corrected read error
//
// The Avalon-MM register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mram_device #(
  parameter int WORDS_LOG2 = mram_port_pkg::WORD_W,
  parameter int LATENCY = mram_port_pkg::READ_LATENCY
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  mram_bus_if.device bus,
  input wire logic upset_strobe,
  input wire logic [mram_port_pkg::DIE_W-1:0] upset_die,
  input wire logic [WORDS_LOG2-1:0] upset_word,
  input wire logic [4:0] upset_bit
);
  import mram_port_pkg::*;

  localparam int CNT_W = WORDS_LOG2 + 1 + DIE_W;
  localparam int MEM_A = DIE_W + WORDS_LOG2;

  // hamming(21,16): check bits at code positions 1,2,4,8,16
  function automatic logic [CODE_W-1:0] encode(input logic [DQ_W-1:0] d);
    logic [CODE_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int i = 0; i < CHK_W; i++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p >> i) & 1) == 1 && (p & (p - 1)) != 0) begin
          c[(1 << i) - 1] ^= c[p-1];
        end
      end
    end
    return c;
  endfunction

  function automatic logic [CHK_W-1:0] syndrome(input logic [CODE_W-1:0] c);
    logic [CHK_W-1:0] s;
    s = '0;
    for (int i = 0; i < CHK_W; i++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if (((p >> i) & 1) == 1) begin
          s[i] ^= c[p-1];
        end
      end
    end
    return s;
  endfunction

  function automatic logic [DQ_W-1:0] extract(input logic [CODE_W-1:0] c);
    logic [DQ_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p-1];
        k++;
      end
    end
    return d;
  endfunction

  // counter to die and byte/word index, depending on width strap
  function automatic logic [DIE_W-1:0] cnt_die(input logic [CNT_W-1:0] c, input logic b8);
    return b8 ? c[CNT_W-1 -: DIE_W] : c[CNT_W-2 -: DIE_W];
  endfunction

  function automatic logic [WORDS_LOG2:0] cnt_idx(input logic [CNT_W-1:0] c, input logic b8);
    return b8 ? c[WORDS_LOG2:0] : {1'b0, c[WORDS_LOG2-1:0]};
  endfunction

  logic [CODE_W-1:0] mem [2**MEM_A];
  logic strap_byte;
  logic strap_taken;
  logic [CNT_W-1:0] counter;
  logic [LATENCY-1:0] p_vld;
  logic [CODE_W-1:0] p_code [LATENCY];
  logic [DIE_W-1:0] p_die [LATENCY];
  logic [LATENCY-1:0] p_lane;
  logic [LATENCY-1:0] p_gate;
  logic [DQ_W-1:0] dev_dq_out;
  logic [DQ_W-1:0] dev_dq_oe;
  logic last_addr;
  logic [DIE_N-1:0] corr_err;

  assign bus.dev_dq_out = dev_dq_out;
  assign bus.dev_dq_oe = dev_dq_oe;
  assign bus.last_addr = last_addr;
  assign bus.corr_err = corr_err;

  // normal access decode
  wire any_sel = ~&bus.die_sel_n;
  wire [DIE_W-1:0] sel_die = !bus.die_sel_n[0] ? 2'd0 : !bus.die_sel_n[1] ? 2'd1 :
    !bus.die_sel_n[2] ? 2'd2 : 2'd3;
  wire [WORDS_LOG2-1:0] norm_word = strap_byte ? bus.cell_index[WORDS_LOG2:1] :
    bus.cell_index[WORDS_LOG2-1:0];
  wire norm_lane = strap_byte & bus.cell_index[0];
  wire normal_wr = !bus.burst_read_mode && any_sel && !bus.write_n;
  wire normal_rd = !bus.burst_read_mode && any_sel && bus.write_n;

  // burst access decode
  wire [WORDS_LOG2:0] burst_idx = cnt_idx(counter, strap_byte);
  wire [DIE_W-1:0] burst_die = cnt_die(counter, strap_byte);
  wire [WORDS_LOG2-1:0] burst_word = strap_byte ? burst_idx[WORDS_LOG2:1] :
    burst_idx[WORDS_LOG2-1:0];
  wire burst_lane = strap_byte & burst_idx[0];
  wire advance = bus.count_arm && !bus.count_stop && bus.wrap_guard;
  wire [CNT_W-1:0] cnt_max = strap_byte ? {CNT_W{1'b1}} : {1'b0, {(CNT_W-1){1'b1}}};
  wire [CNT_W-1:0] next_counter = !bus.burst_read_mode ? '0 :
    !advance ? '0 :
    (counter == cnt_max) ? counter : counter + 1'b1;

  wire rd_any = normal_rd || bus.burst_read_mode;
  wire [DIE_W-1:0] acc_die = bus.burst_read_mode ? burst_die : sel_die;
  wire [WORDS_LOG2-1:0] acc_word = bus.burst_read_mode ? burst_word : norm_word;
  wire acc_lane = bus.burst_read_mode ? burst_lane : norm_lane;
  wire [MEM_A-1:0] acc_addr = {acc_die, acc_word};

  // byte writes merge into the stored word; old data is not corrected first
  wire [DQ_W-1:0] old_data = extract(mem[acc_addr]);
  wire [DQ_W-1:0] new_data = !strap_byte ? bus.dq :
    norm_lane ? {bus.dq[7:0], old_data[7:0]} : {old_data[15:8], bus.dq[7:0]};
  wire [MEM_A-1:0] upset_addr = {upset_die, upset_word};

  // strap caught once after reset release
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_byte <= 1'b0;
      strap_taken <= 1'b0;
    end else if (clk_en && !strap_taken) begin
      strap_byte <= bus.byte_mode_sel;
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      counter <= '0;
    end else if (clk_en) begin
      counter <= next_counter;
    end
  end

  // storage has no reset; a sampled access on every edge
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (normal_wr) begin
        mem[acc_addr] <= encode(new_data);
      end else if (upset_strobe) begin
        mem[upset_addr] <= mem[upset_addr] ^ (CODE_W'(1) << upset_bit);
      end
    end
  end

  // read pipeline, depth fixes the read latency
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      p_vld <= '0;
      p_lane <= '0;
      p_gate <= '0;
      for (int i = 0; i < LATENCY; i++) begin
        p_code[i] <= '0;
        p_die[i] <= '0;
      end
    end else if (clk_en) begin
      p_vld[0] <= rd_any;
      p_code[0] <= mem[acc_addr];
      p_die[0] <= acc_die;
      p_lane[0] <= acc_lane;
      p_gate[0] <= bus.out_gate;
      for (int i = 1; i < LATENCY; i++) begin
        p_vld[i] <= p_vld[i-1];
        p_code[i] <= p_code[i-1];
        p_die[i] <= p_die[i-1];
        p_lane[i] <= p_lane[i-1];
        p_gate[i] <= p_gate[i-1] & bus.out_gate;
      end
    end
  end

  wire [CODE_W-1:0] tail_code = p_code[LATENCY-1];
  wire [CHK_W-1:0] tail_syn = syndrome(tail_code);
  wire tail_fix = tail_syn != '0;
  wire [CODE_W-1:0] fixed_code = (tail_syn <= CHK_W'(CODE_W)) && tail_fix ?
    tail_code ^ (CODE_W'(1) << (tail_syn - 1'b1)) : tail_code;
  wire [DQ_W-1:0] tail_data = extract(fixed_code);
  wire tail_vld = p_vld[LATENCY-1];
  wire tail_drive = tail_vld && p_gate[LATENCY-1] && bus.out_gate;
  wire [DQ_W-1:0] lane_data = !strap_byte ? tail_data :
    {8'h00, p_lane[LATENCY-1] ? tail_data[15:8] : tail_data[7:0]};
  wire [DQ_W-1:0] lane_oe = strap_byte ? 16'h00ff : 16'hffff;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dev_dq_out <= '0;
      dev_dq_oe <= '0;
      last_addr <= 1'b0;
      corr_err <= '0;
    end else if (clk_en) begin
      dev_dq_out <= lane_data;
      dev_dq_oe <= tail_drive ? lane_oe : '0;
      last_addr <= bus.burst_read_mode && (next_counter == cnt_max);
      if (tail_vld) begin
        for (int d = 0; d < DIE_N; d++) begin
          corr_err[d] <= tail_fix && (p_die[LATENCY-1] == DIE_W'(d));
        end
      end
    end
  end
endmodule // mram_device
`default_nettype wire

// ===== src/mram_host.sv
`timescale 1ns/1ps
`default_nettype none
module mram_host #(
  parameter bit BYTE_MODE = 1'b0,
  parameter int LATENCY = mram_port_pkg::READ_LATENCY
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  mram_bus_if.host bus,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  import mram_port_pkg::*;

  typedef enum logic [1:0] {IDLE, ISSUE, WAIT} host_state_t;
  host_state_t state;
  logic [31:0] ctrl, addr, wdata, rdata, irq_mask;
  logic [IRQ_W-1:0] irq_stat;
  logic [BURST_W-1:0] burst_len, beats;
  logic [7:0] wait_cnt;
  logic wait_q;
  logic op_write, op_burst;
  logic [IDX_W-1:0] cell_index;
  logic write_n, out_gate, burst_read_mode, count_arm, count_stop, wrap_guard;
  logic [DIE_N-1:0] die_sel_n;
  logic [DQ_W-1:0] dq_out, dq_oe;

  assign bus.cell_index = cell_index;
  assign bus.write_n = write_n;
  assign bus.die_sel_n = die_sel_n;
  assign bus.out_gate = out_gate;
  assign bus.byte_mode_sel = BYTE_MODE; // tied, never changes
  assign bus.burst_read_mode = burst_read_mode;
  assign bus.count_arm = count_arm;
  assign bus.count_stop = count_stop;
  assign bus.wrap_guard = wrap_guard;
  assign bus.host_dq_out = dq_out;
  assign bus.host_dq_oe = dq_oe;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  wire take = (avs_read || avs_write) && !wait_q;
  wire wr_take = take && avs_write;
  wire rd_take = take && avs_read;
  wire [31:0] wr_val = merge(32'h0, avs_writedata, avs_byteenable);
  wire go = wr_take && avs_address == CTRL_OFS && wr_val[CTRL_GO] && state == IDLE;
  wire [DIE_W-1:0] die = addr[ADDR_DIE_LSB +: DIE_W];
  wire [IDX_W-1:0] idx = BYTE_MODE ? addr[IDX_W-1:0] : {1'b0, addr[IDX_W-2:0]};
  wire [DQ_W-1:0] wr_dq = BYTE_MODE ? {8'h00, wdata[7:0]} : wdata[DQ_W-1:0];
  wire capture = state == WAIT && wait_cnt == '0;
  wire [IRQ_W-1:0] events;
  assign events[IRQ_DONE] = capture;
  // corr_err holds from the last read, so a write must not raise it again
  assign events[IRQ_CORR] = capture && !op_write && |bus.corr_err;
  // flag falls as soon as burst mode ends, so catch it while beats go out
  assign events[IRQ_LAST] = state == ISSUE && op_burst && bus.last_addr;
  wire [31:0] status = {24'h0, bus.corr_err, 2'b00, bus.last_addr, state != IDLE};
  wire [31:0] rd_mux = avs_address == CTRL_OFS ? ctrl :
    avs_address == ADDR_OFS ? addr :
    avs_address == WDATA_OFS ? wdata :
    avs_address == RDATA_OFS ? rdata :
    avs_address == STATUS_OFS ? status :
    avs_address == IRQ_STAT_OFS ? {29'h0, irq_stat} :
    avs_address == IRQ_MASK_OFS ? irq_mask :
    avs_address == BURST_LEN_OFS ? {16'h0, burst_len} : 32'h0;

  // slave: one wait cycle, then answer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 1'b1;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      wait_q <= !(avs_read || avs_write) || !wait_q;
      avs_waitrequest <= !((avs_read || avs_write) && wait_q);
      if ((avs_read || avs_write) && wait_q) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      addr <= '0;
      wdata <= '0;
      irq_mask <= '0;
      burst_len <= BURST_LEN_RESET;
    end else if (clk_en && wr_take) begin
      unique case (avs_address)
        CTRL_OFS: ctrl <= merge(ctrl, avs_writedata, avs_byteenable) & 32'h0000_000e;
        ADDR_OFS: addr <= merge(addr, avs_writedata, avs_byteenable);
        WDATA_OFS: wdata <= merge(wdata, avs_writedata, avs_byteenable);
        IRQ_MASK_OFS: irq_mask <= merge(irq_mask, avs_writedata, avs_byteenable);
        BURST_LEN_OFS: burst_len <= merge({16'h0, burst_len}, avs_writedata,
          avs_byteenable) [BURST_W-1:0];
        default: ;
      endcase
    end
  end

  // status bits sticky, read clears, new event wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      // clear only bits already handed to the master; a later event survives
      irq_stat <= events | ((rd_take && avs_address == IRQ_STAT_OFS) ?
        irq_stat & ~avs_readdata[IRQ_W-1:0] : irq_stat);
      irq <= |(irq_stat & irq_mask[IRQ_W-1:0]);
    end
  end

  // bus sequencer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= IDLE;
      op_write <= 1'b0;
      op_burst <= 1'b0;
      beats <= '0;
      wait_cnt <= '0;
      rdata <= '0;
      cell_index <= '0;
      write_n <= 1'b1;
      die_sel_n <= '1;
      out_gate <= 1'b1;
      burst_read_mode <= 1'b0;
      count_arm <= 1'b0;
      count_stop <= 1'b1;
      wrap_guard <= 1'b1;
      dq_out <= '0;
      dq_oe <= '0;
    end else if (clk_en) begin
      out_gate <= ctrl[CTRL_GATE];
      unique case (state)
        IDLE: begin
          if (go) begin
            state <= ISSUE;
            op_write <= wr_val[CTRL_WRITE] && !wr_val[CTRL_BURST];
            op_burst <= wr_val[CTRL_BURST];
            beats <= burst_len;
            cell_index <= wr_val[CTRL_BURST] ? '0 : idx;
            write_n <= !(wr_val[CTRL_WRITE] || wr_val[CTRL_BURST]);
            die_sel_n <= wr_val[CTRL_BURST] ? '0 : ~(DIE_N'(1) << die);
            burst_read_mode <= wr_val[CTRL_BURST];
            count_arm <= 1'b1;
            count_stop <= 1'b0;
            wrap_guard <= 1'b1;
            dq_out <= wr_dq;
            dq_oe <= (wr_val[CTRL_WRITE] && !wr_val[CTRL_BURST]) ? '1 : '0;
          end
        end
        ISSUE: begin
          if (op_burst && beats > 1) begin
            beats <= beats - 1'b1;
            wrap_guard <= !bus.last_addr;
          end else begin
            state <= WAIT;
            wait_cnt <= op_write ? 8'd0 : 8'(LATENCY);
            write_n <= 1'b1;
            die_sel_n <= '1;
            burst_read_mode <= 1'b0;
            count_arm <= 1'b0;
            count_stop <= 1'b1;
            dq_oe <= '0;
          end
        end
        WAIT: begin
          if (wait_cnt != '0) begin
            wait_cnt <= wait_cnt - 1'b1;
          end else begin
            state <= IDLE;
            if (!op_write) begin
              rdata <= {16'h0, bus.dq};
            end
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // mram_host
`default_nettype wire

// ===== src/mram_port_pkg.sv
package mram_port_pkg;
  // data bus and index widths
  localparam int DQ_W = 16;
  localparam int IDX_W = 21;
  localparam int DIE_N = 4;
  localparam int DIE_W = 2;
  localparam int WORD_W = 20;
  localparam int CHK_W = 5;
  localparam int CODE_W = DQ_W + CHK_W;
  localparam int READ_LATENCY = 2;
  // controller registers, byte offsets on the Avalon-MM slave
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] ADDR_OFS = 5'h04;
  localparam logic [4:0] WDATA_OFS = 5'h08;
  localparam logic [4:0] RDATA_OFS = 5'h0c;
  localparam logic [4:0] STATUS_OFS = 5'h10;
  localparam logic [4:0] IRQ_STAT_OFS = 5'h14;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h18;
  localparam logic [4:0] BURST_LEN_OFS = 5'h1c;
  // ctrl fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_BURST = 2;
  localparam int CTRL_GATE = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;
  // addr fields
  localparam int ADDR_DIE_LSB = 24;
  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_LAST = 1;
  localparam int STAT_ERR_LSB = 4;
  // irq fields
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CORR = 1;
  localparam int IRQ_LAST = 2;
  localparam int IRQ_W = 3;
  localparam int BURST_W = 16;
  localparam logic [BURST_W-1:0] BURST_LEN_RESET = 16'h0001;
endpackage

// ===== testbench/mram_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mram_port_properties
  import mram_port_pkg::*;
#(
  parameter int WORDS_LOG2 = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [mram_port_pkg::IDX_W-1:0] cell_index,
  input wire logic write_n,
  input wire logic [mram_port_pkg::DIE_N-1:0] die_sel_n,
  input wire logic out_gate,
  input wire logic byte_mode_sel,
  input wire logic burst_read_mode,
  input wire logic count_arm,
  input wire logic count_stop,
  input wire logic wrap_guard,
  input wire logic last_addr,
  input wire logic [mram_port_pkg::DIE_N-1:0] corr_err,
  input wire logic [mram_port_pkg::DQ_W-1:0] dev_dq_oe
);
  localparam int CW = DIE_W + WORDS_LOG2;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire normal = !burst_read_mode && (die_sel_n != 4'hf);
  wire rd_any = burst_read_mode || (normal && write_n);
  // reference counter: saturates, any control fault clears it
  logic [CW-1:0] cnt;
  logic exp_last;
  wire clr = !burst_read_mode || !count_arm || count_stop || !wrap_guard;
  wire [CW-1:0] next_cnt = clr ? '0 : ((cnt != '1) ? cnt + 1'b1 : cnt);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      exp_last <= 1'b0;
    end else begin
      cnt <= next_cnt;
      exp_last <= burst_read_mode && (next_cnt == '1);
    end
  end
  sequence s_read;
    normal && write_n && out_gate && !byte_mode_sel ##1 out_gate [*2];
  endsequence
  sequence s_idle;
    !burst_read_mode && die_sel_n == 4'hf;
  endsequence
  sequence s_write;
    normal && !write_n;
  endsequence
  a_read_drives: assert property (s_read |=> dev_dq_oe == 16'hffff)
    else $error("read data not driven after latency");
  a_idle_floats: assert property (s_idle |-> ##3 dev_dq_oe == 16'h0000)
    else $error("deselected access drove the bus");
  a_write_floats: assert property (s_write |-> ##3 dev_dq_oe == 16'h0000)
    else $error("write drove the bus");
  a_gate_floats: assert property (!out_gate |=> dev_dq_oe == 16'h0000)
    else $error("bus driven while gate low");
  a_one_die: assert property (!burst_read_mode |-> $countones(~die_sel_n) <= 1)
    else $error("several dies selected");
  a_burst_selects: assert property (burst_read_mode |-> die_sel_n == 4'h0 && !write_n)
    else $error("burst without all selects and strobe low");
  a_top_index_low: assert property (!byte_mode_sel && normal |-> !cell_index[IDX_W-1])
    else $error("top index bit high in word mode");
  a_last_flag: assert property (last_addr == exp_last)
    else $error("last address flag wrong");
  a_corr_after_read: assert property ($changed(corr_err) |-> $past(rd_any, 3))
    else $error("error flag changed without a read");
endmodule // mram_port_properties
`default_nettype wire

// ===== testbench/sync_mram_port_burst_read_test.sv
`timescale 1ns/1ps
`default_nettype none
module sync_mram_port_burst_read_test;
  import mram_port_pkg::*;
  localparam int WL = 4;
  localparam int N = 1 << (WL + DIE_W);
  localparam int LIMIT = 30000;
  logic clock, resetn, clk_en, avs_read, avs_write, avs_waitrequest, irq, upset_strobe;
  logic [4:0] avs_address, upset_bit;
  logic [31:0] avs_writedata, avs_readdata, q, seed;
  logic [DIE_W-1:0] upset_die;
  logic [WL-1:0] upset_word;
  logic [15:0] mem [N];
  bit flag [N];
  int failures, n_tests, cycles, k, i;
  int lens [3];

  mram_bus_if bus ();
  mram_device #(.WORDS_LOG2(WL), .LATENCY(READ_LATENCY)) u_mram_device (.clock(clock),
    .resetn(resetn), .clk_en(clk_en), .bus(bus), .upset_strobe(upset_strobe),
    .upset_die(upset_die), .upset_word(upset_word), .upset_bit(upset_bit));
  mram_host #(.BYTE_MODE(1'b0), .LATENCY(READ_LATENCY)) u_mram_host (.clock(clock),
    .resetn(resetn), .clk_en(clk_en), .bus(bus), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));
  mram_port_properties #(.WORDS_LOG2(WL)) u_mram_port_properties (.clock(clock),
    .resetn(resetn), .cell_index(bus.cell_index), .write_n(bus.write_n),
    .die_sel_n(bus.die_sel_n), .out_gate(bus.out_gate), .byte_mode_sel(bus.byte_mode_sel),
    .burst_read_mode(bus.burst_read_mode), .count_arm(bus.count_arm),
    .count_stop(bus.count_stop), .wrap_guard(bus.wrap_guard), .last_addr(bus.last_addr),
    .corr_err(bus.corr_err), .dev_dq_oe(bus.dev_dq_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one Avalon transfer; waits for waitrequest low, only the timeout ends it
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic run(input logic [31:0] ctrl);
    av(1'b1, CTRL_OFS, ctrl);
    for (int j = 0; j < 40; j++) begin
      av(1'b0, STATUS_OFS, 32'h0);
      if (q[STAT_BUSY] === 1'b0) break;
    end
    check("busy", 32'h0, q & 32'h1);
  endtask

  function automatic logic [31:0] addr(input int n);
    return ((n >> WL) << ADDR_DIE_LSB) | (n & ((1 << WL) - 1));
  endfunction

  task automatic put(input int n, input logic [15:0] d);
    av(1'b1, ADDR_OFS, addr(n));
    av(1'b1, WDATA_OFS, {16'h0, d});
    run(32'h0000_000b);
    mem[n] = d;
    flag[n] = 1'b0;
  endtask

  task automatic get(input int n, input logic gate);
    av(1'b1, ADDR_OFS, addr(n));
    run(gate ? 32'h0000_0009 : 32'h0000_0001);
    av(1'b0, RDATA_OFS, 32'h0);
    check("rdata", gate ? {16'h0, mem[n]} : 32'h0, q & 32'hffff);
    if (gate) begin
      av(1'b0, STATUS_OFS, 32'h0);
      check("corr_err", flag[n] ? 32'h1 << (n >> WL) : 32'h0, (q >> STAT_ERR_LSB) & 32'hf);
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      final_report();
    end
  end

  initial begin
    resetn = 1'b0;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    upset_strobe = 1'b0;
    upset_die = '0;
    upset_word = '0;
    upset_bit = 5'h00;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    seed = 32'h4c9c818a;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    av(1'b0, CTRL_OFS, 32'h0);
    check("ctrl reset", CTRL_RESET, q);
    av(1'b0, BURST_LEN_OFS, 32'h0);
    check("burst_len reset", {16'h0, BURST_LEN_RESET}, q);
    av(1'b0, IRQ_MASK_OFS, 32'h0);
    check("irq_mask reset", 32'h0, q);
    av(1'b1, 5'h1e, 32'hffff_ffff);
    av(1'b0, 5'h1e, 32'h0);
    check("unmapped", 32'h0, q);
    for (k = 0; k < N; k++) put(k, 16'(rnd()));
    // done interrupt: unmasked, cleared by read, masked
    av(1'b1, IRQ_MASK_OFS, 32'h1);
    av(1'b0, IRQ_STAT_OFS, 32'h0);
    check("irq_stat done", 32'h1, q & 32'h1);
    repeat (2) @(posedge clock);
    check("irq cleared", 32'h0, {31'h0, irq});
    for (i = 0; i < 12; i++) get(int'(rnd() % N), 1'b1);
    check("irq raised", 32'h1, {31'h0, irq});
    av(1'b1, IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge clock);
    check("irq masked", 32'h0, {31'h0, irq});
    // a single stored bit upset must read back corrected and flagged
    k = int'(rnd() % N);
    @(posedge clock);
    upset_die <= DIE_W'(k >> WL);
    upset_word <= WL'(k);
    upset_bit <= 5'(rnd() % 21);
    upset_strobe <= 1'b1;
    @(posedge clock);
    upset_strobe <= 1'b0;
    flag[k] = 1'b1;
    get(k, 1'b1);
    av(1'b0, IRQ_STAT_OFS, 32'h0);
    check("irq corr", 32'h2, q & 32'h2);
    get((k + 1) % N, 1'b1);
    av(1'b0, IRQ_STAT_OFS, 32'h0);
    check("irq corr clear", 32'h0, q & 32'h2);
    put(k, 16'(rnd()));
    get(k, 1'b1);
    get(k, 1'b0);
    // short burst, exit must restart the counter, then a full sweep
    lens = '{3, N - 3, N};
    foreach (lens[j]) begin
      av(1'b0, IRQ_STAT_OFS, 32'h0);
      av(1'b1, BURST_LEN_OFS, lens[j]);
      run(32'h0000_000d);
      av(1'b0, IRQ_STAT_OFS, 32'h0);
      check("last flag", (lens[j] == N) ? 32'h4 : 32'h0, q & 32'h4);
      // last beat of a burst from counter 0 reads cell lens-1
      av(1'b0, RDATA_OFS, 32'h0);
      check("burst rdata", {16'h0, mem[lens[j] - 1]}, q & 32'hffff);
    end
    get(int'(rnd() % N), 1'b1);
    final_report();
  end
endmodule // sync_mram_port_burst_read_test
`default_nettype wire
